// >>> sbcr_partner_model.sv
// Purpose: fuse store and eeprom boot engine seen from the register group
// Assumes: mode 0 done, 1 nack, 2 bad checksum, 3 endless arbitration loss
// Notes: idle data lines toggle so stale values are never read
`timescale 1ns/1ps
module sbcr_partner_model
    import sbcr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [1:0] mode,
    input wire sbcr_fuse_t img,
    input wire logic ee_start,
    input wire logic ee_abort,
    output logic fuse_valid,
    output sbcr_fuse_t fuse_cfg,
    output logic ee_arb_lost,
    output logic ee_nack,
    output logic ee_crc_bad,
    output logic ee_done,
    output logic ee_byte_valid,
    output logic [15:0] ee_byte_addr,
    output logic [7:0] ee_byte_data
);
    logic [7:0] cnt; // cycles since reset release
    logic [7:0] k; // cycles since eeprom start
    logic run; // eeprom read in progress
    wire logic hit = run && k == 8'h04; // moment of the outcome
    assign fuse_cfg = img;
    // one fuse word early, then the eeprom read on demand
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {cnt, k, run, fuse_valid, ee_arb_lost} <= '0;
            {ee_nack, ee_crc_bad, ee_done, ee_byte_valid} <= '0;
            ee_byte_addr <= 16'hffff;
            ee_byte_data <= 8'h00;
        end else begin
            cnt <= (cnt == 8'hff) ? cnt : cnt + 8'h01;
            fuse_valid <= cnt == 8'h02;
            run <= (run || ee_start) && !ee_abort && !ee_done;
            k <= run ? k + 8'h01 : 8'h00;
            ee_byte_valid <= run && k == 8'h02;
            ee_byte_addr <= (run && k == 8'h02) ? 16'h0005 : ~ee_byte_addr;
            ee_byte_data <= (run && k == 8'h02) ? 8'h81 : ~ee_byte_data;
            ee_done <= hit && mode == 2'h0;
            ee_nack <= hit && mode == 2'h1;
            ee_crc_bad <= hit && mode == 2'h2;
            ee_arb_lost <= run && mode == 2'h3 && k >= 8'h04 && !k[0] && !ee_arb_lost;
        end
    end
endmodule // sbcr_partner_model

// >>> sbcr_pkg.sv
// Purpose: constants and carrier types of the startup / identification register group
// Assumes: byte-wide registers behind a 16-bit register address
// Notes: reset values of order-dependent fields come from the fuse store at run time
package sbcr_pkg;
    // register offsets
    localparam logic [15:0] SBCR_OFS_BOOT_SEL = 16'h0000;
    localparam logic [15:0] SBCR_OFS_EE_ADDR = 16'h0001;
    localparam logic [15:0] SBCR_OFS_ID_HIGH = 16'h0002;
    localparam logic [15:0] SBCR_OFS_ID_MID = 16'h0003;
    localparam logic [15:0] SBCR_OFS_ID_LOW = 16'h0004;
    localparam logic [15:0] SBCR_OFS_VARIANT = 16'h0005;
    // register block ranges
    localparam logic [15:0] SBCR_STARTUP_LO = 16'h0000;
    localparam logic [15:0] SBCR_STARTUP_HI = 16'h0001;
    localparam logic [15:0] SBCR_IDENT_LO = 16'h0002;
    localparam logic [15:0] SBCR_IDENT_HI = 16'h0005;
    localparam logic [15:0] SBCR_SERIF_LO = 16'h0006;
    localparam logic [15:0] SBCR_SERIF_HI = 16'h0007;
    localparam logic [15:0] SBCR_PLLDIV_LO = 16'h0033;
    localparam logic [15:0] SBCR_PLLDIV_HI = 16'h003e;
    localparam logic [15:0] SBCR_OUTBUF_LO = 16'h003f;
    localparam logic [15:0] SBCR_OUTBUF_HI = 16'h0048;
    localparam logic [15:0] SBCR_OUTDIV_LO = 16'h0049;
    localparam logic [15:0] SBCR_OUTDIV_HI = 16'h008c;
    // field positions
    localparam int SBCR_RETRY_LSB = 3;
    localparam int SBCR_SKIP_FUSE_BIT = 1;
    localparam int SBCR_SKIP_EE_BIT = 0;
    localparam int SBCR_WIDE_BIT = 7;
    localparam int SBCR_SPEED_BIT = 0;
    // eeprom byte that carries the bus speed select
    localparam logic [15:0] SBCR_EE_SPEED_BYTE = 16'h0005;
    // reset values
    localparam logic [4:0] SBCR_RETRY_RST = 5'h01;
    localparam logic [7:0] SBCR_ADDR_RST = 8'h00;
    localparam logic [10:0] SBCR_VARIANT_RST = 11'h000;
    localparam logic [3:0] SBCR_REV_RST = 4'h3; // arbitrary value
    localparam logic [15:0] SBCR_PART_RST = 16'h5a17; // arbitrary value
    // constant low bit of the variant register
    localparam logic SBCR_VARIANT_B0 = 1'b1;

    // host access over the serial control port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } sbcr_req_t;

    // values delivered by the factory fuse store
    typedef struct packed {
        logic [4:0] retry_limit;
        logic skip_full_fuse_load;
        logic skip_eeprom_load;
        logic eeprom_wide_addressing;
        logic [6:0] eeprom_slave_address;
        logic [10:0] variant_code;
    } sbcr_fuse_t;

    // block selects for the address being accessed
    typedef struct packed {
        logic startup;
        logic ident;
        logic serial_if;
        logic pll_div;
        logic out_buf;
        logic out_div;
    } sbcr_sel_t;

    // boot sequencer states
    typedef enum logic [1:0] {
        SBCR_ST_FUSE,
        SBCR_ST_EE_START,
        SBCR_ST_EE_LOAD,
        SBCR_ST_READY
    } sbcr_state_t;
endpackage

// >>> sbcr_retry_ctl.sv
// Purpose: counts bus arbitration losses of the eeprom boot read
// Assumes: one arb_lost pulse per lost attempt
// Notes: the first attempt is never counted as a retry
`timescale 1ns/1ps
module sbcr_retry_ctl
    import sbcr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic arb_lost,
    input wire logic [4:0] limit,
    output logic retry,
    output logic give_up
);
    logic [4:0] used; // retries already spent

    // limit reached: the next loss aborts
    wire exhausted = (used == limit);

    assign retry = arb_lost && !exhausted;
    assign give_up = arb_lost && exhausted;

    // cleared per load so a repeated boot gets the full budget
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            used <= 5'h00;
        end else if (start) begin
            used <= 5'h00;
        end else if (retry) begin
            used <= 5'(used + 5'h01);
        end
    end
endmodule // sbcr_retry_ctl

// >>> sbcr_startup_monitor.sv
// Purpose: protocol checker for the startup / identification register group
// Assumes: one clock domain, asynchronous active-low reset
// Notes: sees only ports of sbcr_startup_regs
`timescale 1ns/1ps
module sbcr_startup_monitor
    import sbcr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic host_valid,
    input wire logic host_ready,
    input wire sbcr_req_t host_req,
    input wire logic host_rdata_valid,
    input wire sbcr_sel_t host_sel,
    input wire logic fuse_valid,
    input wire sbcr_fuse_t fuse_cfg,
    input wire logic fuse_load_full,
    input wire logic ee_start,
    input wire logic ee_retry,
    input wire logic ee_abort,
    input wire logic ee_two_byte_addr,
    input wire logic [6:0] ee_slave_addr,
    input wire logic ee_arb_lost,
    input wire logic boot_busy,
    input wire logic boot_load_failed
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // taken host requests
    wire logic rd_take = host_valid && host_ready && host_req.rd;
    wire logic wr0_take = host_valid && host_ready && host_req.wr && host_req.addr == 16'h0000;
    wire logic [15:0] a = host_req.addr;
    // skip path: two edges after the fuse word the port opens, no eeprom start
    sequence s_skip_done;
        !ee_start ##1 (!ee_start && !boot_busy);
    endsequence
    // eeprom start is a lone pulse inside the boot
    sequence s_start_once;
        ##1 (!ee_start && boot_busy);
    endsequence
    AST_SEL_LOW: assert property (
        host_sel.startup == (a <= 16'h0001)
        && host_sel.ident == (a >= 16'h0002 && a <= 16'h0005)
        && host_sel.serial_if == (a >= 16'h0006 && a <= 16'h0007))
        else $error("low block decode wrong");
    AST_SEL_HIGH: assert property (
        host_sel.pll_div == (a >= 16'h0033 && a <= 16'h003e)
        && host_sel.out_buf == (a >= 16'h003f && a <= 16'h0048)
        && host_sel.out_div == (a >= 16'h0049 && a <= 16'h008c))
        else $error("high block decode wrong");
    AST_RETRY_CAUSE: assert property (ee_retry |-> ee_arb_lost && !ee_abort)
        else $error("retry without loss");
    AST_LOAD_FULL: assert property (
        wr0_take |=> fuse_load_full == !$past(host_req.wdata[1]))
        else $error("fuse load mode wrong");
    AST_SKIP_EE: assert property (
        fuse_valid && boot_busy && fuse_cfg.skip_eeprom_load |-> ##1 s_skip_done)
        else $error("skip path wrong");
    AST_START_CFG: assert property (
        ee_start |-> ee_slave_addr == fuse_cfg.eeprom_slave_address
        && ee_two_byte_addr == fuse_cfg.eeprom_wide_addressing)
        else $error("eeprom address setup wrong");
    AST_START_PULSE: assert property (ee_start |-> s_start_once)
        else $error("start not a pulse");
    AST_ABORT_FLAG: assert property (ee_abort |=> boot_load_failed && !boot_busy)
        else $error("abort not flagged");
    AST_FAIL_STICKY: assert property (boot_load_failed |=> boot_load_failed)
        else $error("failure flag dropped");
    AST_PORT_SHUT: assert property (host_ready |-> !boot_busy)
        else $error("port open during boot");
    AST_READ_ANS: assert property (rd_take |=> host_rdata_valid)
        else $error("read not answered");
    AST_READ_ONLY: assert property (host_rdata_valid |-> $past(rd_take))
        else $error("spurious read data");
endmodule // sbcr_startup_monitor

bind sbcr_startup_regs sbcr_startup_monitor i_sbcr_startup_monitor (
    .core_clk(core_clk), .rst_n(rst_n), .host_valid(host_valid), .host_ready(host_ready),
    .host_req(host_req), .host_rdata_valid(host_rdata_valid), .host_sel(host_sel),
    .fuse_valid(fuse_valid), .fuse_cfg(fuse_cfg), .fuse_load_full(fuse_load_full),
    .ee_start(ee_start), .ee_retry(ee_retry), .ee_abort(ee_abort),
    .ee_two_byte_addr(ee_two_byte_addr), .ee_slave_addr(ee_slave_addr),
    .ee_arb_lost(ee_arb_lost), .boot_busy(boot_busy), .boot_load_failed(boot_load_failed));

// >>> sbcr_startup_regs.sv
// Purpose: startup control and identification registers with boot sequencing
// Assumes: serial port slave and boot read engine sit outside, on core_clk
// Notes: host accesses are refused while the eeprom boot load runs
//
// How it works
// - startup 0-1, ident 2-5, serial 6-7
// - pll 33-3E, buffers 3F-48, dividers 49-8C
// - retry field counts extra arbitration tries
// - skip bit chooses full or eight-byte fuse load
// - skip bit chooses eeprom overwrite or none
// - wide bit means two-byte eeprom addressing
// - offset 1 bits 6-0 are eeprom address
// - eleven-bit variant code, host writable once boot completes
// - nack or bad checksum aborts, flags failure
// - host ignored during eeprom boot load
// - eeprom byte 05 bit 0 selects fast
`timescale 1ns/1ps
module sbcr_startup_regs
    import sbcr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    // host port from the serial control slave
    input wire logic host_valid,
    output logic host_ready,
    input wire sbcr_req_t host_req,
    output logic [7:0] host_rdata,
    output logic host_rdata_valid,
    output sbcr_sel_t host_sel,
    // factory fuse store
    input wire logic fuse_valid,
    input wire sbcr_fuse_t fuse_cfg,
    output logic fuse_load_full,
    // eeprom boot read engine
    output logic ee_start,
    output logic ee_retry,
    output logic ee_abort,
    output logic ee_two_byte_addr,
    output logic [6:0] ee_slave_addr,
    output logic ee_fast_speed,
    input wire logic ee_arb_lost,
    input wire logic ee_nack,
    input wire logic ee_crc_bad,
    input wire logic ee_done,
    input wire logic ee_byte_valid,
    input wire logic [15:0] ee_byte_addr,
    input wire logic [7:0] ee_byte_data,
    // status
    output logic boot_busy,
    output logic boot_load_failed
);
    // true when addr lies within lo..hi inclusive
    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                      input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // register fields named as in the host map
    sbcr_state_t state; // boot sequencer state
    sbcr_state_t next_state;
    logic [4:0] eeprom_retry_limit; // startup register fields
    logic skip_full_fuse_load;
    logic skip_eeprom_load;
    logic eeprom_wide_addressing;
    logic [6:0] eeprom_slave_address;
    logic [3:0] silicon_revision; // identity fields
    logic [15:0] part_identifier;
    logic [10:0] variant_code;
    logic fuse_taken; // fuse values have been captured
    logic give_up; // arbitration budget spent

    // sequencer decodes
    wire in_fuse = (state == SBCR_ST_FUSE);
    wire in_load = (state == SBCR_ST_EE_LOAD);
    wire ready = (state == SBCR_ST_READY);
    // engine pulses outside the load are ignored,
    // so a stray one cannot fail an idle boot
    wire fail_evt = in_load && (ee_nack || ee_crc_bad || give_up);

    // host may only touch registers after boot completes
    // shut from reset on, so no write races the fuse preset
    assign host_ready = ready;
    wire host_wr = host_valid && host_ready && host_req.wr;
    wire host_rd = host_valid && host_ready && host_req.rd;

    // eeprom image writes land only while the load runs
    wire ee_wr = in_load && ee_byte_valid;

    // one write port shared by host and eeprom; they never overlap in time
    // eeprom wins the mux; the host port is shut then
    wire wr_en = host_wr || ee_wr;
    wire [15:0] wr_addr = ee_wr ? ee_byte_addr : host_req.addr;
    wire [7:0] wr_data = ee_wr ? ee_byte_data : host_req.wdata;

    // per register write strobes
    // unmapped offsets get no strobe: writes vanish
    wire wr_boot = wr_en && (wr_addr == SBCR_OFS_BOOT_SEL);
    wire wr_eaddr = wr_en && (wr_addr == SBCR_OFS_EE_ADDR);
    wire wr_idh = wr_en && (wr_addr == SBCR_OFS_ID_HIGH);
    wire wr_idm = wr_en && (wr_addr == SBCR_OFS_ID_MID);
    wire wr_idl = wr_en && (wr_addr == SBCR_OFS_ID_LOW);
    wire wr_var = wr_en && (wr_addr == SBCR_OFS_VARIANT);

    // block decode handed to the rest of the register map
    // follows the address even while the port is shut;
    // downstream blocks qualify it with their own accept
    assign host_sel.startup = in_range(host_req.addr, SBCR_STARTUP_LO,
                                       SBCR_STARTUP_HI);
    assign host_sel.ident = in_range(host_req.addr, SBCR_IDENT_LO,
                                     SBCR_IDENT_HI);
    assign host_sel.serial_if = in_range(host_req.addr, SBCR_SERIF_LO,
                                         SBCR_SERIF_HI);
    assign host_sel.pll_div = in_range(host_req.addr, SBCR_PLLDIV_LO,
                                       SBCR_PLLDIV_HI);
    assign host_sel.out_buf = in_range(host_req.addr, SBCR_OUTBUF_LO,
                                       SBCR_OUTBUF_HI);
    assign host_sel.out_div = in_range(host_req.addr, SBCR_OUTDIV_LO,
                                       SBCR_OUTDIV_HI);

    // read images; reserved bits read as zero
    // tying reserved bits low costs nothing
    wire [7:0] rd_boot = {eeprom_retry_limit, 1'b0, skip_full_fuse_load, skip_eeprom_load};
    wire [7:0] rd_eaddr = {eeprom_wide_addressing, eeprom_slave_address};
    wire [7:0] rd_idh = {silicon_revision, part_identifier[15:12]};
    wire [7:0] rd_idm = part_identifier[11:4];
    wire [7:0] rd_idl = {part_identifier[3:0], variant_code[10:7]};
    wire [7:0] rd_var = {variant_code[6:0], SBCR_VARIANT_B0};

    // read mux; unmapped offsets answer zero
    // exact offsets keep this mux small
    logic [7:0] rd_mux;
    always_comb begin
        case (host_req.addr)
            SBCR_OFS_BOOT_SEL: rd_mux = rd_boot;
            SBCR_OFS_EE_ADDR: rd_mux = rd_eaddr;
            SBCR_OFS_ID_HIGH: rd_mux = rd_idh;
            SBCR_OFS_ID_MID: rd_mux = rd_idm;
            SBCR_OFS_ID_LOW: rd_mux = rd_idl;
            SBCR_OFS_VARIANT: rd_mux = rd_var;
            default: rd_mux = 8'h00;
        endcase
    end

    // boot sequencer: fuse, then optional eeprom, then open to the host
    // READY is terminal: one boot per reset, so a
    // late engine pulse cannot restart the load
    always_comb begin
        next_state = state;
        case (state)
            SBCR_ST_FUSE: begin
                // fuse settled; eeprom decision uses the fresh fuse bit
                if (fuse_taken) begin
                    next_state = skip_eeprom_load ? SBCR_ST_READY
                                                  : SBCR_ST_EE_START;
                end
            end
            SBCR_ST_EE_START: next_state = SBCR_ST_EE_LOAD;
            SBCR_ST_EE_LOAD: begin
                // failure and completion both end the load
                if (fail_evt || ee_done) begin
                    next_state = SBCR_ST_READY;
                end
            end
            SBCR_ST_READY: next_state = SBCR_ST_READY;
            default: next_state = SBCR_ST_FUSE;
        endcase
    end

    // state register
    // async clear shuts the port at once
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SBCR_ST_FUSE;
        end else begin
            state <= next_state;
        end
    end

    // fuse capture happens once, before any eeprom traffic
    // a long fuse_valid still presets only once
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fuse_taken <= 1'b0;
        end else if (in_fuse && fuse_valid) begin
            fuse_taken <= 1'b1;
        end
    end

    // startup control registers: fuse preset, then eeprom or host writes
    // reset values hold only until the fuse word;
    // eeprom image and host may overwrite any field
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            eeprom_retry_limit <= SBCR_RETRY_RST;
            skip_full_fuse_load <= 1'b0;
            skip_eeprom_load <= 1'b1;
            eeprom_wide_addressing <= SBCR_ADDR_RST[SBCR_WIDE_BIT];
            eeprom_slave_address <= SBCR_ADDR_RST[6:0];
        end else if (in_fuse && fuse_valid && !fuse_taken) begin
            eeprom_retry_limit <= fuse_cfg.retry_limit;
            skip_full_fuse_load <= fuse_cfg.skip_full_fuse_load;
            skip_eeprom_load <= fuse_cfg.skip_eeprom_load;
            eeprom_wide_addressing <= fuse_cfg.eeprom_wide_addressing;
            eeprom_slave_address <= fuse_cfg.eeprom_slave_address;
        end else begin
            if (wr_boot) begin
                eeprom_retry_limit <= wr_data[7:SBCR_RETRY_LSB];
                skip_full_fuse_load <= wr_data[SBCR_SKIP_FUSE_BIT];
                skip_eeprom_load <= wr_data[SBCR_SKIP_EE_BIT];
            end
            if (wr_eaddr) begin
                eeprom_wide_addressing <= wr_data[SBCR_WIDE_BIT];
                eeprom_slave_address <= wr_data[6:0];
            end
        end
    end

    // identity registers: writable, variant code preset from fuse
    // revision and part id have no fuse source
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            silicon_revision <= SBCR_REV_RST;
            part_identifier <= SBCR_PART_RST;
            variant_code <= SBCR_VARIANT_RST;
        end else if (in_fuse && fuse_valid && !fuse_taken) begin
            variant_code <= fuse_cfg.variant_code;
        end else begin
            if (wr_idh) begin
                silicon_revision <= wr_data[7:4];
                part_identifier[15:12] <= wr_data[3:0];
            end
            if (wr_idm) begin
                part_identifier[11:4] <= wr_data;
            end
            if (wr_idl) begin
                part_identifier[3:0] <= wr_data[7:4];
                variant_code[10:7] <= wr_data[3:0];
            end
            if (wr_var) begin
                variant_code[6:0] <= wr_data[7:1];
            end
        end
    end

    // eeprom speed: slow until image byte 05 asks for fast
    // cleared at start so each load begins slow
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ee_fast_speed <= 1'b0;
        end else if (state == SBCR_ST_EE_START) begin
            ee_fast_speed <= 1'b0;
        end else if (ee_wr && (ee_byte_addr == SBCR_EE_SPEED_BYTE)) begin
            ee_fast_speed <= ee_byte_data[SBCR_SPEED_BIT];
        end
    end

    // failure flag stays set; a later boot does not occur without reset
    // only reset clears it, so it can be read late
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_load_failed <= 1'b0;
        end else if (fail_evt) begin
            boot_load_failed <= 1'b1;
        end
    end

    // read data is registered at the edge that accepts the read
    // rdata keeps its value between reads
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_rdata <= 8'h00;
            host_rdata_valid <= 1'b0;
        end else begin
            host_rdata_valid <= host_rd;
            if (host_rd) begin
                host_rdata <= rd_mux;
            end
        end
    end

    // engine controls
    // straight from the registers, no extra delay; ee_abort follows the engine inputs
    assign ee_start = (state == SBCR_ST_EE_START);
    assign ee_abort = fail_evt;
    assign ee_two_byte_addr = eeprom_wide_addressing;
    assign ee_slave_addr = eeprom_slave_address;
    assign fuse_load_full = !skip_full_fuse_load;
    assign boot_busy = !ready;

    // arbitration retry budget
    // restarts on ee_start: each load gets the full budget
    sbcr_retry_ctl u_retry (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(ee_start),
        .arb_lost(ee_arb_lost && in_load),
        .limit(eeprom_retry_limit),
        .retry(ee_retry),
        .give_up(give_up)
    );
endmodule // sbcr_startup_regs

// >>> sbcr_startup_regs_tb.sv
// Purpose: self-checking bench of the startup / identification register group
// Assumes: partner model plays fuse store and eeprom engine
// Notes: every boot needs a fresh reset
`timescale 1ns/1ps
module sbcr_startup_regs_tb;
    import sbcr_pkg::*;
    logic core_clk = 1'b0, rst_n = 1'b0, host_valid = 1'b0;
    sbcr_req_t host_req = '0;
    logic host_ready, host_rdata_valid, fuse_valid, fuse_load_full, ee_start, ee_retry, ee_abort;
    logic ee_two_byte_addr, ee_fast_speed, ee_arb_lost, ee_nack, ee_crc_bad, ee_done;
    logic ee_byte_valid, boot_busy, boot_load_failed;
    logic [7:0] host_rdata, ee_byte_data;
    logic [15:0] ee_byte_addr;
    logic [6:0] ee_slave_addr;
    sbcr_sel_t host_sel;
    sbcr_fuse_t fuse_cfg, img = '0;
    logic [1:0] mode = 2'h0;
    int err_total = 0, checked = 0, starts, retries;
    // fuse images: skipping eeprom, and using it
    localparam sbcr_fuse_t IMG_SKIP = '{5'h02, 1'b1, 1'b1, 1'b1, 7'h50, 11'h123};
    localparam sbcr_fuse_t IMG_EE = '{5'h02, 1'b0, 1'b0, 1'b1, 7'h50, 11'h123};

    initial forever #2.5 core_clk = ~core_clk;

    sbcr_startup_regs i_sbcr_startup_regs (.core_clk(core_clk), .rst_n(rst_n),
        .host_valid(host_valid), .host_ready(host_ready), .host_req(host_req),
        .host_rdata(host_rdata), .host_rdata_valid(host_rdata_valid), .host_sel(host_sel),
        .fuse_valid(fuse_valid), .fuse_cfg(fuse_cfg), .fuse_load_full(fuse_load_full),
        .ee_start(ee_start), .ee_retry(ee_retry), .ee_abort(ee_abort),
        .ee_two_byte_addr(ee_two_byte_addr), .ee_slave_addr(ee_slave_addr),
        .ee_fast_speed(ee_fast_speed), .ee_arb_lost(ee_arb_lost), .ee_nack(ee_nack),
        .ee_crc_bad(ee_crc_bad), .ee_done(ee_done), .ee_byte_valid(ee_byte_valid),
        .ee_byte_addr(ee_byte_addr), .ee_byte_data(ee_byte_data), .boot_busy(boot_busy),
        .boot_load_failed(boot_load_failed));
    sbcr_partner_model i_sbcr_partner_model (.core_clk(core_clk), .rst_n(rst_n), .mode(mode),
        .img(img), .ee_start(ee_start), .ee_abort(ee_abort), .fuse_valid(fuse_valid),
        .fuse_cfg(fuse_cfg), .ee_arb_lost(ee_arb_lost), .ee_nack(ee_nack),
        .ee_crc_bad(ee_crc_bad), .ee_done(ee_done), .ee_byte_valid(ee_byte_valid),
        .ee_byte_addr(ee_byte_addr), .ee_byte_data(ee_byte_data));

    // count engine pulses of the current boot
    always @(posedge core_clk) begin
        starts <= !rst_n ? 0 : starts + int'(ee_start);
        retries <= !rst_n ? 0 : retries + int'(ee_retry);
    end

    // the one comparison of values
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic hwr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        host_valid <= 1'b1;
        host_req <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk);
        host_valid <= 1'b0;
    endtask

    // read answer stands just after the edge that takes the request
    task automatic hrd(input logic [15:0] a, input logic [7:0] e);
        @(posedge core_clk);
        host_valid <= 1'b1;
        host_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge core_clk);
        host_valid <= 1'b0;
        #1;
        chk({7'h00, host_rdata_valid, host_rdata}, {8'h01, e}, "read");
    endtask

    // reset, boot with image f and engine mode m, wait until the port opens
    task automatic boot(input sbcr_fuse_t f, input logic [1:0] m);
        int n;
        @(posedge core_clk);
        rst_n <= 1'b0;
        img <= f;
        mode <= m;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        for (n = 0; n < 300 && host_ready !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
            if (boot_busy === 1'b1) chk(host_ready, '0, "port open in boot");
        end
        if (n >= 300) begin
            err_total++;
            $display("[ERR] %0t boot never finished", $time);
            summarize();
        end
    endtask

    task automatic t_decode();
        sbcr_sel_t e;
        for (int a = 0; a < 16'h0090; a++) begin
            @(posedge core_clk);
            host_req <= '{1'b0, 1'b0, a[15:0], 8'h00};
            #1;
            e = '{a <= 1, a >= 2 && a <= 5, a >= 6 && a <= 7, a >= 'h33 && a <= 'h3e,
                a >= 'h3f && a <= 'h48, a >= 'h49 && a <= 'h8c};
            chk(host_sel, e, "decode");
        end
        $display("test decode done");
    endtask

    task automatic t_skip();
        boot(IMG_SKIP, 2'h3);
        chk(16'(starts), '0, "eeprom touched");
        chk(fuse_load_full, '0, "partial fuse load");
        hrd(16'h0000, 8'h13);
        hrd(16'h0001, 8'hd0);
        hrd(16'h0002, {SBCR_REV_RST, SBCR_PART_RST[15:12]});
        hrd(16'h0003, SBCR_PART_RST[11:4]);
        hrd(16'h0004, {SBCR_PART_RST[3:0], 4'h2});
        hrd(16'h0005, 8'h47);
        $display("test skip done");
    endtask

    task automatic t_abort();
        for (int m = 1; m <= 3; m++) begin
            boot(IMG_EE, m[1:0]);
            chk(16'(starts), 16'h0001, "one start");
            chk(16'(retries), (m == 3) ? 16'h0002 : 16'h0000, "retry count");
            chk({ee_two_byte_addr, ee_slave_addr}, 8'hd0, "eeprom addressing");
            chk(boot_load_failed, 16'h0001, "failure flag");
        end
        $display("test abort done");
    endtask

    task automatic t_load();
        boot(IMG_EE, 2'h0);
        chk({boot_load_failed, ee_fast_speed}, 2'b01, "clean load");
        hrd(16'h0005, 8'h81);
        hwr(16'h0005, 8'h40);
        hrd(16'h0005, 8'h41);
        hwr(16'h0004, 8'h75);
        hrd(16'h0004, 8'h75);
        hwr(16'h0000, 8'h0b);
        #1;
        chk(fuse_load_full, '0, "fuse mode low");
        hwr(16'h0000, 8'h09);
        hrd(16'h0000, 8'h09);
        hwr(16'h0040, 8'h5a);
        hrd(16'h0040, 8'h00);
        $display("test load done");
    endtask

    initial begin
        t_decode();
        t_skip();
        t_abort();
        t_load();
        summarize();
    end
endmodule // sbcr_startup_regs_tb
